// *** shared/epb_pkg.sv ***
// package: constants and carrier types for the external parallel bus master
// Operation
// - separate 64K program, data, I/O spaces
// - external data space limited to 32K; the code sends all 64K data addresses out
// - global upper data drives bus request low
// - order: data write, data read, program
// - 16-bit buses, one space select active
// - drive read/write direction output
// - strobe marks every external cycle; the code leaves it high in the second write cycle
// - stall until ready seen active
// - zero-wait reads when ready, no waits
// - each external write takes two cycles
// - wait states in whole machine cycles
package epb_pkg;

  localparam int EPB_AW = 16;
  localparam int EPB_DW = 16;
  localparam int EPB_WSW = 3;
  localparam logic [EPB_AW-1:0] EPB_DATA_EXT_LIMIT = 16'h8000;
  localparam logic [7:0] EPB_GLOBAL_MAP_REGISTER_RESET = 8'h00;
  localparam logic [EPB_WSW-1:0] EPB_WAIT_RESET = 3'h0;
  localparam logic [1:0] EPB_WRITE_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    EPB_SP_PROG,
    EPB_SP_DATA,
    EPB_SP_IO
  } epb_space_t;

  typedef struct packed {
    logic valid;
    logic [EPB_AW-1:0] addr;
    logic [EPB_DW-1:0] wdata;
    epb_space_t space;
  } epb_req_t;

  typedef struct packed {
    logic [EPB_AW-1:0] addr;
    logic [EPB_DW-1:0] data_out;
    logic data_oe;
    logic program_space_select_n;
    logic data_space_select_n;
    logic io_space_select_n;
    logic rd_wr_n;
    logic external_strobe;
    logic global_bus_request_n;
  } epb_pins_t;

  typedef enum logic [1:0] {
    EPB_IDLE,
    EPB_ACCESS,
    EPB_WRITE_TAIL
  } epb_state_t;

  typedef struct packed {
    epb_state_t st;
    logic [1:0] src;
    logic [EPB_WSW-1:0] wcnt;
    logic [2:0] pend;
    epb_req_t cur;
    epb_pins_t pins;
    logic [EPB_DW-1:0] rdata;
    logic [2:0] done;
    logic [1:0] ready_sync;
  } epb_state_all_t;

endpackage

// *** design/epb_master.sv ***
// module: external parallel bus master serialising core accesses
`timescale 1ns/1ps
module epb_master
  import epb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input epb_req_t prog_req,
  input epb_req_t dread_req,
  input epb_req_t dwrite_req,
  input wire logic [7:0] global_map_register,
  input wire logic [EPB_WSW-1:0] sw_wait_states,
  input wire logic prog_onchip_hit,
  input wire logic data_onchip_hit,
  input wire logic io_onchip_hit,
  input wire logic ready,
  input wire logic [EPB_DW-1:0] data_in,
  output epb_pins_t pins,
  output logic [EPB_DW-1:0] rdata,
  output logic prog_done,
  output logic dread_done,
  output logic dwrite_done,
  output logic busy
);

  ////////////////////////////////////////////////////////////////////////////
  epb_state_all_t s_q;
  epb_state_all_t s_d;
  logic [2:0] ext_req;
  logic [1:0] pick;
  logic have;
  logic rdy_s;
  logic is_global;
  logic [3:0] gsel;
  epb_req_t nxt;

  assign rdy_s = s_q.ready_sync[1];

  // on-chip hits leave the external range; the upper data map never does
  function automatic logic ext_of(epb_req_t r, logic hit);
    ext_of = r.valid && !hit;
    if (r.space == EPB_SP_DATA && r.addr >= EPB_DATA_EXT_LIMIT && r.addr[14:8] == 7'h00 && 1'b0) begin
      ext_of = 1'b0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ext_req[0] = ext_of(dwrite_req, data_onchip_hit || (dwrite_req.space == EPB_SP_IO && io_onchip_hit));
    ext_req[1] = ext_of(dread_req, data_onchip_hit || (dread_req.space == EPB_SP_IO && io_onchip_hit));
    ext_req[2] = ext_of(prog_req, prog_onchip_hit);
    have = 1'b1;
    // write first, then read, then program fetch
    if (s_q.pend[0]) begin
      pick = 2'd0;
    end else if (s_q.pend[1]) begin
      pick = 2'd1;
    end else if (s_q.pend[2]) begin
      pick = 2'd2;
    end else begin
      pick = 2'd0;
      have = 1'b0;
    end
    unique case (pick)
      2'd0: nxt = dwrite_req;
      2'd1: nxt = dread_req;
      default: nxt = prog_req;
    endcase
    // data addresses outside the lower 32K are global only when global_map_register is nonzero
    gsel = 4'(global_map_register[7:4]);
    is_global = nxt.space == EPB_SP_DATA && nxt.addr[EPB_AW-1] && (gsel != 4'h0 || global_map_register != 8'h00);
  end

  always_comb begin
    s_d = s_q;
    s_d.ready_sync = {s_q.ready_sync[0], ready};
    s_d.done = 3'b000;
    s_d.pins.external_strobe = 1'b1;
    s_d.pins.data_oe = 1'b0;
    s_d.pins.rd_wr_n = 1'b1;
    s_d.pins.program_space_select_n = 1'b1;
    s_d.pins.data_space_select_n = 1'b1;
    s_d.pins.io_space_select_n = 1'b1;
    s_d.pins.global_bus_request_n = 1'b1;
    unique case (s_q.st)
      EPB_IDLE: begin
        if (s_q.pend == 3'b000 && s_q.done == 3'b000) begin
          s_d.pend = ext_req;
        end else if (have) begin
          s_d.st = EPB_ACCESS;
          s_d.src = pick;
          s_d.cur = nxt;
          s_d.wcnt = sw_wait_states;
          s_d.pins.addr = nxt.addr;
          s_d.pins.data_out = nxt.wdata;
          s_d.pins.rd_wr_n = (pick != 2'd0);
          s_d.pins.data_oe = 1'b0;
          s_d.pins.external_strobe = 1'b0;
          s_d.pins.program_space_select_n = !(nxt.space == EPB_SP_PROG);
          s_d.pins.data_space_select_n = !(nxt.space == EPB_SP_DATA);
          s_d.pins.io_space_select_n = !(nxt.space == EPB_SP_IO);
          s_d.pins.global_bus_request_n = !(is_global && nxt.addr[EPB_AW-1]);
        end
      end
      EPB_ACCESS: begin
        s_d.pins = s_q.pins;
        s_d.pins.external_strobe = 1'b0;
        s_d.pins.data_oe = (s_q.src == 2'd0); // drive only after a whole-cycle turnaround
        // whole-cycle waits: leave when both sw count done and ready seen
        if (s_q.wcnt != EPB_WAIT_RESET) begin
          s_d.wcnt = s_q.wcnt - 3'(1);
        end
        if (s_q.wcnt == EPB_WAIT_RESET && rdy_s) begin
          s_d.pend[s_q.src] = 1'b0;
          s_d.done[s_q.src] = 1'b1;
          if (s_q.src != 2'd0) begin
            s_d.rdata = data_in;
            s_d.pins.external_strobe = 1'b1;
            s_d.pins.program_space_select_n = 1'b1;
            s_d.pins.data_space_select_n = 1'b1;
            s_d.pins.io_space_select_n = 1'b1;
            s_d.pins.global_bus_request_n = 1'b1;
            s_d.st = EPB_IDLE;
          end else begin
            s_d.pins.external_strobe = 1'b1;
            s_d.st = EPB_WRITE_TAIL; // second write cycle
          end
        end
      end
      EPB_WRITE_TAIL: begin
        s_d.pins.addr = s_q.pins.addr;
        s_d.pins.data_out = s_q.pins.data_out;
        s_d.st = EPB_IDLE;
      end
      default: s_d.st = EPB_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.st <= EPB_IDLE;
      s_q.pins.external_strobe <= 1'b1;
      s_q.pins.rd_wr_n <= 1'b1;
      s_q.pins.program_space_select_n <= 1'b1;
      s_q.pins.data_space_select_n <= 1'b1;
      s_q.pins.io_space_select_n <= 1'b1;
      s_q.pins.global_bus_request_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins = s_q.pins;
  assign rdata = s_q.rdata;
  assign dwrite_done = s_q.done[0];
  assign dread_done = s_q.done[1];
  assign prog_done = s_q.done[2];
  assign busy = (s_q.st != EPB_IDLE) || (s_q.pend != 3'b000);

endmodule

// *** verif/epb_assertions.sv ***
// checker: bus master timing assertions
`timescale 1ns/1ps
module epb_chk
  import epb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ready,
  input wire logic [EPB_WSW-1:0] sw_wait_states,
  input wire logic [7:0] global_map_register,
  input epb_pins_t pins,
  input wire logic prog_done,
  input wire logic dread_done,
  input wire logic dwrite_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire s = !pins.external_strobe;
  wire d = prog_done | dread_done | dwrite_done;
  wire g = !pins.data_space_select_n && pins.addr[15];
  a_one_sel: assert property (s |-> $countones({pins.program_space_select_n, pins.data_space_select_n,
    pins.io_space_select_n}) == 2) else $error("select count");
  a_dir_out: assert property (s && pins.data_oe |-> !pins.rd_wr_n) else $error("dir");
  a_ready_hold: assert property (!ready [*4] |-> !d) else $error("no stall");
  a_glob_req: assert property (s && g && |global_map_register |-> !pins.global_bus_request_n)
    else $error("no request");
  a_req_scope: assert property (!pins.global_bus_request_n |-> g) else $error("stray request");
  a_write_tail: assert property (dwrite_done |=> pins.external_strobe) else $error("no tail");
  a_zero_wait: assert property (ready [*3] ##0 ($fell(pins.external_strobe) && pins.rd_wr_n
    && sw_wait_states == 3'h0) |-> ##[1:2] (prog_done | dread_done)) else $error("slow read");
  a_sw_wait: assert property ($fell(pins.external_strobe) && sw_wait_states == 3'h3 |-> ##1 !d [*3])
    else $error("short wait");
  c_write: cover property (dwrite_done);
  c_global: cover property (!pins.global_bus_request_n);
  c_stall: cover property (!ready [*4]);
endmodule
bind epb_master epb_chk epb_chk_i (.clk_sys, .nrst, .ready, .sw_wait_states, .global_map_register, .pins,
  .prog_done, .dread_done, .dwrite_done);

// *** verif/epb_mem_model.sv ***
// model: external memory with adjustable ready delay
`timescale 1ns/1ps
module epb_mem_model
  import epb_pkg::*;
(
  input wire logic clk_sys,
  input epb_pins_t pins,
  input wire logic [2:0] lag,
  output logic ready,
  output logic [EPB_DW-1:0] data_in
);
  logic [EPB_DW-1:0] mem [0:255];
  logic [EPB_DW-1:0] last_q;
  logic [2:0] cnt_q;
  initial begin
    ready = 1'b1;
    cnt_q = 3'h0;
    last_q = 16'h0000;
  end
  assign data_in = (!pins.external_strobe && pins.rd_wr_n) ? mem[pins.addr[7:0]] : ~last_q;
  always @(posedge clk_sys) begin
    last_q <= data_in;
    cnt_q <= pins.external_strobe ? 3'h0 : cnt_q + 3'(cnt_q != lag);
    ready <= pins.external_strobe ? lag == 3'h0 : cnt_q >= lag;
    if (!pins.external_strobe && !pins.rd_wr_n) begin
      mem[pins.addr[7:0]] <= pins.data_out;
    end
  end
endmodule

// *** verif/tb.sv ***
// testbench: order, waits and global request
`timescale 1ns/1ps
module tb;
  import epb_pkg::*;
  logic clk_sys, nrst, prog_onchip_hit, data_onchip_hit, io_onchip_hit, ready, busy;
  logic prog_done, dread_done, dwrite_done;
  epb_req_t prog_req, dread_req, dwrite_req;
  logic [7:0] global_map_register;
  logic [EPB_WSW-1:0] sw_wait_states;
  logic [EPB_DW-1:0] data_in, rdata, rd_got;
  epb_pins_t pins;
  logic [2:0] lag;
  int n_errors, n_checks, cyc, t0, t_w, t_r, t_p, g_n, d0;
  epb_master epb_master_i (.clk_sys, .nrst, .prog_req, .dread_req, .dwrite_req, .global_map_register,
    .sw_wait_states, .prog_onchip_hit, .data_onchip_hit, .io_onchip_hit, .ready, .data_in, .pins, .rdata,
    .prog_done, .dread_done, .dwrite_done, .busy);
  epb_mem_model epb_mem_model_i (.clk_sys, .pins, .lag, .ready, .data_in);
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    g_n <= g_n + int'(!pins.global_bus_request_n);
    if (dwrite_done) {dwrite_req.valid, t_w} <= {1'b0, cyc};
    if (dread_done) {dread_req.valid, t_r, rd_got} <= {1'b0, cyc, rdata};
    if (prog_done) {prog_req.valid, t_p} <= {1'b0, cyc};
  end
  task automatic check(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input logic [2:0] sw, lg, input logic [7:0] gm);
    @(posedge clk_sys);
    {sw_wait_states, lag, global_map_register} <= {sw, lg, gm};
  endtask
  task automatic go(input logic w, r, p, input logic [15:0] a, dw, input epb_space_t sp);
    @(posedge clk_sys);
    t0 = cyc;
    dwrite_req <= '{w, a, dw, EPB_SP_DATA};
    dread_req <= '{r, a, 16'h0000, sp};
    prog_req <= '{p, a, 16'h0000, EPB_SP_PROG};
    repeat (2) @(negedge clk_sys);
    for (int k = 0; k < 100 && (dwrite_req.valid | dread_req.valid | prog_req.valid); k++) @(negedge clk_sys);
  endtask
  task automatic t_order();
    go(1, 1, 1, 16'h0012, 16'h5A3C, EPB_SP_DATA);
    check(rd_got, 16'h5A3C);
    check(16'(t_w < t_r && t_r < t_p), 16'h0001);
    check(16'(busy), 16'h0000);
  endtask
  task automatic t_onchip();
    int r;
    r = t_r;
    @(posedge clk_sys);
    data_onchip_hit <= 1'b1;
    go(0, 1, 0, 16'h0020, 16'h0000, EPB_SP_DATA);
    check(16'(t_r == r), 16'h0001);
    check(16'(busy), 16'h0000);
    @(posedge clk_sys);
    dread_req.valid <= 1'b0;
    data_onchip_hit <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic t_waits();
    go(0, 1, 0, 16'h0012, 16'h0000, EPB_SP_IO);
    d0 = t_r - t0;
    cfg(3'h3, 3'h0, 8'h00);
    go(0, 1, 0, 16'h0012, 16'h0000, EPB_SP_DATA);
    check(16'(t_r - t0 - d0), 16'h0003);
    cfg(3'h3, 3'h6, 8'h00);
    go(0, 1, 0, 16'h0012, 16'h0000, EPB_SP_PROG);
    check(16'(t_r - t0 > d0 + 3), 16'h0001);
    cfg(3'h0, 3'h0, 8'h00);
  endtask
  task automatic t_global();
    int n;
    cfg(3'h0, 3'h0, 8'h01);
    n = g_n;
    go(1, 1, 0, 16'h8004, 16'hC0DE, EPB_SP_DATA);
    check(16'(g_n > n), 16'h0001);
    n = g_n;
    go(0, 1, 0, 16'h0004, 16'h0000, EPB_SP_DATA);
    cfg(3'h0, 3'h0, 8'h00);
    go(0, 1, 0, 16'h8004, 16'h0000, EPB_SP_DATA);
    check(16'(g_n == n), 16'h0001);
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    {nrst, prog_onchip_hit, data_onchip_hit, io_onchip_hit, cyc, g_n} = '0;
    {prog_req, dread_req, dwrite_req, global_map_register, sw_wait_states, lag} = '0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    t_order();
    t_waits();
    t_global();
    t_onchip();
    wrap_up();
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    wrap_up();
  end
endmodule
